/* File: pkg/tal_pkg.sv */
// Constants and carrier types of the thermal alert logic.
// Assumes one 100 MHz core clock; conversion pins come from another domain.
package tal_pkg;

    // Register offsets on the register port
    localparam logic [7:0] OFS_LOCAL_READING  = 8'h00;
    localparam logic [7:0] OFS_CONFIG         = 8'h01;
    localparam logic [7:0] OFS_LOCAL_LOW      = 8'h02;
    localparam logic [7:0] OFS_LOCAL_HIGH     = 8'h03;
    localparam logic [7:0] OFS_REMOTE_READING = 8'h10;
    localparam logic [7:0] OFS_REMOTE_LOW     = 8'h12;
    localparam logic [7:0] OFS_REMOTE_HIGH    = 8'h13;
    localparam logic [7:0] OFS_OT_RELEASE     = 8'h22;
    localparam logic [7:0] OFS_OT_LIMIT       = 8'h23;

    // Power-on values, diode-fault full-scale reading and unmapped read data
    localparam logic [7:0] RST_READING     = 8'h00;
    localparam logic [7:0] RST_CONFIG      = 8'h00;
    localparam logic [7:0] RST_LOCAL_LOW   = 8'h4C;
    localparam logic [7:0] RST_LOCAL_HIGH  = 8'h51;
    localparam logic [7:0] RST_REMOTE_LOW  = 8'h5C;
    localparam logic [7:0] RST_REMOTE_HIGH = 8'h61;
    localparam logic [7:0] RST_OT_RELEASE  = 8'h5C;
    localparam logic [7:0] RST_OT_LIMIT    = 8'h61;
    localparam logic [7:0] FULL_SCALE      = 8'h7F;
    localparam logic [7:0] UNMAPPED_DATA   = 8'h00;

    // Configuration field positions
    localparam int CFG_SLEEP       = 0;
    localparam int CFG_MODE        = 1;
    localparam int CFG_MASK        = 2;
    localparam int CFG_DEPTH_LO    = 3;
    localparam int CFG_DEPTH_HI    = 4;
    localparam int CFG_OT_FLAG     = 5;
    localparam int CFG_REMOTE_FLAG = 6;
    localparam int CFG_LOCAL_FLAG  = 7;

    // Consecutive-conversion counts per depth code
    localparam int          CNT_W   = 3;
    localparam logic [2:0]  DEPTH_0 = 3'h1;
    localparam logic [2:0]  DEPTH_1 = 3'h2;
    localparam logic [2:0]  DEPTH_2 = 3'h4;
    localparam logic [2:0]  DEPTH_3 = 3'h6;

    // Conversion pins from the converter
    typedef struct packed {
        logic       clk;
        logic       zone;
        logic       fault;
        logic [7:0] data;
    } tal_conv_s;

    // Register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } tal_req_s;

    typedef enum logic [0:0] {
        TAL_ZONE_LOCAL  = 1'b0,
        TAL_ZONE_REMOTE = 1'b1
    } tal_zone_e;

endpackage

/* File: rtl/tal_alert.sv */
// Event detection, filtering and alert pins of a two-zone thermal supervisor.
// Assumes converter pins arrive asynchronously and are captured on convClk rise;
// the register port is driven from core_clk logic.
//
// Notes on behaviour
// - Sleep bit set stops conversions; clearing it resumes them.
// - All registers stay readable, and limit and control registers writable, during sleep.
// - Comparator mode: sleep entry leaves alert pin as it was.
// - Interrupt mode: sleep entry releases alert, clears local/remote flags.
// - Sleep entry never changes overtemp pin or its flag.
// - No events during sleep; diode faults seen only after a conversion.
// - Depth field 00/01/10/11 selects 1/2/4/6 conversions, default 00.
// - Threshold condition valid only after the selected consecutive count.
// - Local, remote and overtemp filters are independent.
// - Validated high events, and low events in interrupt mode, set status flags whatever the mask.
// - Alert pin driven only while mask bit is zero.
// - Interrupt mode: any register read releases alert.
// - Reading configuration clears local and remote flags.
// - After high event wait for low, after low wait for high.
// - Conversions continue while alert is pending.
// - Overtemp pin set above limit, released below release; flag mirrors pin.
// - Overtemp ignores mode and mask.
// - Polling host sets mask; alert then never sinks.
// - Repeated events leave a flag set, no counting.
// - Diode fault forces full scale remote reading, tripping remote events.
// - Readings and limits are 8-bit two's complement degrees.
// - Mode bit 1 selects latched interrupt, 0 comparator.
// - Comparator: a zone's flag clears when its reading falls below its low limit; alert clears once neither zone is still high.
`timescale 1ns/1ps
`default_nettype none

module tal_alert (
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              reset_n,
    // Register port
    input  wire tal_pkg::tal_req_s regReq,
    output logic [7:0]             regRdData,
    // Converter pins
    input  wire tal_pkg::tal_conv_s convPins,
    output logic                   convEnable,
    // Open-drain alert pin
    output logic                   alertOut,
    output logic                   alertOe,
    // Open-drain overtemp pin
    output logic                   overtempOut,
    output logic                   overtempOe
);

    // Synchronised converter pins
    tal_pkg::tal_conv_s convSync1_ff;
    tal_pkg::tal_conv_s convSync2_ff;
    logic               convClkPrev_ff;

    // Register file
    logic [7:0] localReading_ff;
    logic [7:0] remoteReading_ff;
    logic [7:0] localLowLimit_ff;
    logic [7:0] localHighLimit_ff;
    logic [7:0] remoteLowLimit_ff;
    logic [7:0] remoteHighLimit_ff;
    logic [7:0] otReleaseLimit_ff;
    logic [7:0] otLimit_ff;
    logic [4:0] cfgCtrl_ff;

    // Event state
    logic       sleepPrev_ff;
    logic       localFlag_ff;
    logic       remoteFlag_ff;
    logic       otFlag_ff;
    logic       localLastHigh_ff;
    logic       remoteLastHigh_ff;
    logic       alertPend_ff;
    logic       alertOe_ff;
    logic       convEnable_ff;
    logic       driveLow_ff;
    logic [7:0] regRdData_ff;
    logic [tal_pkg::CNT_W-1:0] filterCnt_ff [6];

    // Control fields
    wire       sleepBit  = cfgCtrl_ff[tal_pkg::CFG_SLEEP];
    wire       modeInt   = cfgCtrl_ff[tal_pkg::CFG_MODE];
    wire       maskBit   = cfgCtrl_ff[tal_pkg::CFG_MASK];
    wire [1:0] depthCode = cfgCtrl_ff[tal_pkg::CFG_DEPTH_HI:tal_pkg::CFG_DEPTH_LO];
    wire       sleepEnter = sleepBit & ~sleepPrev_ff;

    // Depth code to consecutive count
    wire [tal_pkg::CNT_W-1:0] depthCount =
        (depthCode == 2'b00) ? tal_pkg::DEPTH_0 :
        (depthCode == 2'b01) ? tal_pkg::DEPTH_1 :
        (depthCode == 2'b10) ? tal_pkg::DEPTH_2 : tal_pkg::DEPTH_3;

    // Conversion capture on rising converter clock, gated by sleep
    wire convRise = convSync2_ff.clk & ~convClkPrev_ff;
    wire convDone = convRise & ~sleepBit;
    wire zoneRemote = (convSync2_ff.zone == tal_pkg::TAL_ZONE_REMOTE);
    wire localDone  = convDone & ~zoneRemote;
    wire remoteDone = convDone & zoneRemote;
    wire [7:0] newReading = convSync2_ff.fault ? tal_pkg::FULL_SCALE
                                               : convSync2_ff.data;

    // Signed threshold conditions on the new reading
    wire [5:0] cond;
    assign cond[0] = $signed(newReading) > $signed(localHighLimit_ff);
    assign cond[1] = $signed(newReading) < $signed(localLowLimit_ff);
    assign cond[2] = $signed(newReading) > $signed(remoteHighLimit_ff);
    assign cond[3] = $signed(newReading) < $signed(remoteLowLimit_ff);
    assign cond[4] = $signed(newReading) > $signed(otLimit_ff);
    assign cond[5] = $signed(newReading) < $signed(otReleaseLimit_ff);

    // Per-condition filters: local pair, remote pair, overtemp pair
    logic [5:0] valid;
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_filter
            wire step = (gi < 2) ? localDone : remoteDone;
            wire [tal_pkg::CNT_W-1:0] cntInc = filterCnt_ff[gi] + 3'h1;
            wire atDepth = (cntInc >= depthCount);
            wire [tal_pkg::CNT_W-1:0] nxt_cnt =
                !step     ? filterCnt_ff[gi] :
                !cond[gi] ? '0 :
                atDepth   ? depthCount : cntInc;
            assign valid[gi] = step & cond[gi] & atDepth;
            always_ff @(posedge core_clk) begin
                if (!reset_n) begin
                    filterCnt_ff[gi] <= '0;
                end else begin
                    filterCnt_ff[gi] <= nxt_cnt;
                end
            end
        end
    endgenerate

    // Zone events with high/low alternation
    wire localHiEv  = valid[0] & ~localLastHigh_ff;
    wire localLoEv  = valid[1] &  localLastHigh_ff;
    wire remoteHiEv = valid[2] & ~remoteLastHigh_ff;
    wire remoteLoEv = valid[3] &  remoteLastHigh_ff;
    wire anyEvent   = localHiEv | localLoEv | remoteHiEv | remoteLoEv;
    wire nxt_localLastHigh  = localHiEv  | (localLastHigh_ff  & ~localLoEv);
    wire nxt_remoteLastHigh = remoteHiEv | (remoteLastHigh_ff & ~remoteLoEv);

    // Register decode
    wire cfgRead  = regReq.rd & (regReq.addr == tal_pkg::OFS_CONFIG);
    wire wrConfig = regReq.wr & (regReq.addr == tal_pkg::OFS_CONFIG);
    wire wrLocLo  = regReq.wr & (regReq.addr == tal_pkg::OFS_LOCAL_LOW);
    wire wrLocHi  = regReq.wr & (regReq.addr == tal_pkg::OFS_LOCAL_HIGH);
    wire wrRemLo  = regReq.wr & (regReq.addr == tal_pkg::OFS_REMOTE_LOW);
    wire wrRemHi  = regReq.wr & (regReq.addr == tal_pkg::OFS_REMOTE_HIGH);
    wire wrOtRel  = regReq.wr & (regReq.addr == tal_pkg::OFS_OT_RELEASE);
    wire wrOtLim  = regReq.wr & (regReq.addr == tal_pkg::OFS_OT_LIMIT);

    // Status flags: set wins over clear
    wire localSet  = localHiEv  | (modeInt & localLoEv);
    wire remoteSet = remoteHiEv | (modeInt & remoteLoEv);
    wire localClr  = cfgRead | (~modeInt & localLoEv)  | (modeInt & sleepEnter);
    wire remoteClr = cfgRead | (~modeInt & remoteLoEv) | (modeInt & sleepEnter);
    wire nxt_localFlag  = localSet  | (localFlag_ff  & ~localClr);
    wire nxt_remoteFlag = remoteSet | (remoteFlag_ff & ~remoteClr);

    // Overtemp level, untouched by mode, mask and sleep
    wire nxt_otFlag = valid[4] | (otFlag_ff & ~valid[5]);

    // Latched alert request: events set, any read or sleep entry clears
    wire nxt_alertPend = anyEvent | (alertPend_ff & ~(regReq.rd | sleepEnter));
    wire cmpLevel      = nxt_localLastHigh | nxt_remoteLastHigh;
    wire nxt_alertOe   = ~maskBit & (modeInt ? (nxt_alertPend & ~sleepEnter)
                                              : cmpLevel);

    // Read data selection
    wire [7:0] cfgValue = {localFlag_ff, remoteFlag_ff, otFlag_ff, cfgCtrl_ff};
    logic [7:0] nxt_regRdData;
    always_comb begin
        unique case (regReq.addr)
            tal_pkg::OFS_LOCAL_READING:  nxt_regRdData = localReading_ff;
            tal_pkg::OFS_CONFIG:         nxt_regRdData = cfgValue;
            tal_pkg::OFS_LOCAL_LOW:      nxt_regRdData = localLowLimit_ff;
            tal_pkg::OFS_LOCAL_HIGH:     nxt_regRdData = localHighLimit_ff;
            tal_pkg::OFS_REMOTE_READING: nxt_regRdData = remoteReading_ff;
            tal_pkg::OFS_REMOTE_LOW:     nxt_regRdData = remoteLowLimit_ff;
            tal_pkg::OFS_REMOTE_HIGH:    nxt_regRdData = remoteHighLimit_ff;
            tal_pkg::OFS_OT_RELEASE:     nxt_regRdData = otReleaseLimit_ff;
            tal_pkg::OFS_OT_LIMIT:       nxt_regRdData = otLimit_ff;
            default:                     nxt_regRdData = tal_pkg::UNMAPPED_DATA;
        endcase
    end

    // Two-flop synchroniser and edge memory for converter pins
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            convSync1_ff   <= '0;
            convSync2_ff   <= '0;
            convClkPrev_ff <= 1'b0;
        end else begin
            convSync1_ff   <= convPins;
            convSync2_ff   <= convSync1_ff;
            convClkPrev_ff <= convSync2_ff.clk;
        end
    end

    // Reading registers
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            localReading_ff  <= tal_pkg::RST_READING;
            remoteReading_ff <= tal_pkg::RST_READING;
        end else begin
            if (localDone) localReading_ff <= newReading;
            if (remoteDone) remoteReading_ff <= newReading;
        end
    end

    // Limit and control registers, writable in any state
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            localLowLimit_ff   <= tal_pkg::RST_LOCAL_LOW;
            localHighLimit_ff  <= tal_pkg::RST_LOCAL_HIGH;
            remoteLowLimit_ff  <= tal_pkg::RST_REMOTE_LOW;
            remoteHighLimit_ff <= tal_pkg::RST_REMOTE_HIGH;
            otReleaseLimit_ff  <= tal_pkg::RST_OT_RELEASE;
            otLimit_ff         <= tal_pkg::RST_OT_LIMIT;
            cfgCtrl_ff         <= tal_pkg::RST_CONFIG[4:0];
        end else begin
            if (wrLocLo) localLowLimit_ff <= regReq.wdata;
            if (wrLocHi) localHighLimit_ff <= regReq.wdata;
            if (wrRemLo) remoteLowLimit_ff <= regReq.wdata;
            if (wrRemHi) remoteHighLimit_ff <= regReq.wdata;
            if (wrOtRel) otReleaseLimit_ff <= regReq.wdata;
            if (wrOtLim) otLimit_ff <= regReq.wdata;
            if (wrConfig) cfgCtrl_ff <= regReq.wdata[4:0];
        end
    end

    // Event state and flags
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            sleepPrev_ff      <= 1'b0;
            localFlag_ff      <= 1'b0;
            remoteFlag_ff     <= 1'b0;
            otFlag_ff         <= 1'b0;
            localLastHigh_ff  <= 1'b0;
            remoteLastHigh_ff <= 1'b0;
            alertPend_ff      <= 1'b0;
        end else begin
            sleepPrev_ff      <= sleepBit;
            localFlag_ff      <= nxt_localFlag;
            remoteFlag_ff     <= nxt_remoteFlag;
            otFlag_ff         <= nxt_otFlag;
            localLastHigh_ff  <= nxt_localLastHigh;
            remoteLastHigh_ff <= nxt_remoteLastHigh;
            alertPend_ff      <= nxt_alertPend;
        end
    end

    // Output flops
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            alertOe_ff    <= 1'b0;
            convEnable_ff <= 1'b0;
            driveLow_ff   <= 1'b0;
            regRdData_ff  <= '0;
        end else begin
            alertOe_ff    <= nxt_alertOe;
            convEnable_ff <= ~sleepBit;
            driveLow_ff   <= 1'b0;
            regRdData_ff  <= regReq.rd ? nxt_regRdData : '0;
        end
    end

    // Port drive: open-drain pins only ever pull low
    assign regRdData   = regRdData_ff;
    assign convEnable  = convEnable_ff;
    assign alertOut    = driveLow_ff;
    assign alertOe     = alertOe_ff;
    assign overtempOut = driveLow_ff;
    assign overtempOe  = otFlag_ff;

    // Checks on the guarded behaviour
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    // Sleep entry and sleep state
    sleep_stops_conv_a: assert property (sleepBit |=> !convEnable)
        else $error("conversions enabled while asleep");
    sleep_write_a: assert property (
        sleepBit && wrOtLim |=> otLimit_ff == $past(regReq.wdata))
        else $error("limit write lost during sleep");
    cmp_sleep_hold_a: assert property (
        sleepEnter && !modeInt && $stable(modeInt) && $stable(maskBit)
            |=> alertOe == $past(alertOe))
        else $error("comparator alert moved on sleep entry");
    int_sleep_clear_a: assert property (
        sleepEnter && modeInt |=> !alertOe && !localFlag_ff && !remoteFlag_ff)
        else $error("interrupt state kept on sleep entry");
    ot_sleep_hold_a: assert property (sleepBit |=> overtempOe == $past(overtempOe))
        else $error("overtemp changed during sleep");
    no_event_sleep_a: assert property (sleepBit |-> !convDone && !anyEvent)
        else $error("event detected during sleep");

    // Consecutive-count filters
    filter_count_a: assert property (
        $rose(otFlag_ff) |-> ({1'b0, $past(filterCnt_ff[4])} + 4'h1) >= {1'b0, $past(depthCount)})
        else $error("overtemp set before filter depth");
    depth_six_a: assert property (
        depthCode == 2'b11 && filterCnt_ff[0] == 3'h4 |-> !valid[0])
        else $error("depth code 11 accepted before six conversions");
    filter_reset_a: assert property (localDone && !cond[0] |=> filterCnt_ff[0] == 3'h0)
        else $error("local filter kept count on a failed conversion");
    filter_hold_a: assert property (
        !localDone |=> filterCnt_ff[0] == $past(filterCnt_ff[0]))
        else $error("local filter moved without a local conversion");
    ot_filter_apart_a: assert property (
        localDone |=> filterCnt_ff[4] == $past(filterCnt_ff[4]))
        else $error("overtemp filter moved on a local conversion");

    // Status flags and alert pin
    local_flag_set_a: assert property (localHiEv |=> localFlag_ff)
        else $error("local flag not set by high event");
    remote_flag_set_a: assert property (remoteHiEv |=> remoteFlag_ff)
        else $error("remote flag not set by high event");
    flag_sticky_a: assert property (
        localFlag_ff && !cfgRead && !sleepEnter && !localLoEv |=> localFlag_ff)
        else $error("local flag lost without a clear");
    mask_gate_a: assert property ($past(maskBit) |-> !alertOe)
        else $error("alert driven while masked");
    read_release_a: assert property (
        modeInt && regReq.rd && !anyEvent && !wrConfig |=> !alertOe)
        else $error("read did not release alert");
    cfg_read_clear_a: assert property (
        cfgRead && !anyEvent |=> !localFlag_ff && !remoteFlag_ff)
        else $error("flags not cleared by config read");
    cmp_low_clear_a: assert property (
        !modeInt && localLoEv && !remoteLastHigh_ff |=> !alertOe && !localFlag_ff)
        else $error("comparator alert kept after low event");
    conv_alert_a: assert property (
        alertOe && localDone |=> localReading_ff == $past(newReading))
        else $error("conversion dropped while alert pending");

    // Overtemp pin and diode-fault reading
    ot_unmasked_a: assert property (valid[4] |=> overtempOe)
        else $error("overtemp not raised by a valid condition");
    ot_release_a: assert property (valid[5] && !valid[4] |=> !overtempOe)
        else $error("overtemp kept after release condition");
    ot_mirror_a: assert property (
        cfgRead |=> regRdData[tal_pkg::CFG_OT_FLAG] == $past(overtempOe))
        else $error("overtemp flag does not mirror pin");
    fault_reading_a: assert property (
        remoteDone && convSync2_ff.fault |=> remoteReading_ff == tal_pkg::FULL_SCALE)
        else $error("diode fault did not force full scale");

    // Main scenarios
    cover_int_alert: cover property (modeInt && !alertOe ##1 alertOe);
    cover_ot_rise: cover property ($rose(overtempOe));
    cover_int_sleep: cover property (sleepEnter && modeInt && alertOe);
    cover_diode_fault: cover property (remoteDone && convSync2_ff.fault);
    cover_depth_six: cover property (depthCode == 2'b11 && valid[0]);

endmodule

`default_nettype wire

/* File: bench/tal_conv_model.sv */
// Behavioural converter that feeds finished conversions to the alert logic.
// Assumes the caller spaces calls; the strobe stands low between frames.
`timescale 1ns/1ps
`default_nettype none

module tal_conv_model (
    // Converter pins towards the block
    output var tal_pkg::tal_conv_s pins
);
    // Idle pins at time zero
    initial begin
        pins = '0;
    end

    // One conversion: strobe high then low, 125 ns in all
    task automatic convert(input logic z, input logic [7:0] d, input logic f);
        // Non-blocking so a call at a clock edge never races the synchroniser
        pins <= '{clk: 1'b1, zone: z, fault: f, data: d};
        #62.5 pins.clk <= 1'b0;
        // Released zone and data lines show the inverse so stale data never looks valid
        #62.5 pins <= '{clk: 1'b0, zone: ~z, fault: 1'b0, data: ~d};
    endtask
endmodule

`default_nettype wire

/* File: bench/tal_alert_bench.sv */
// Self-checking bench for the thermal alert logic.
// Assumes the converter model in tal_conv_model and the 100 MHz core clock.
`timescale 1ns/1ps
`default_nettype none

module tal_alert_bench;
    logic               core_clk;
    logic               reset_n;
    tal_pkg::tal_req_s  regReq;
    tal_pkg::tal_conv_s convPins;
    logic [7:0]         regRdData;
    logic               convEnable;
    logic               alertOut;
    logic               alertOe;
    logic               overtempOut;
    logic               overtempOe;
    int                 n_fail;
    int                 comparisons;
    int                 cycleCount;
    int                 cnt;
    logic [2:0]         depthCnt [4] = '{3'h1, 3'h2, 3'h4, 3'h6};

    tal_alert dut (
        .core_clk    (core_clk),
        .reset_n     (reset_n),
        .regReq      (regReq),
        .regRdData   (regRdData),
        .convPins    (convPins),
        .convEnable  (convEnable),
        .alertOut    (alertOut),
        .alertOe     (alertOe),
        .overtempOut (overtempOut),
        .overtempOe  (overtempOe)
    );

    tal_conv_model conv (
        .pins (convPins)
    );

    // Core clock and time-zero values
    initial begin
        core_clk = 1'b0;
        reset_n = 1'b0;
        regReq = '0;
        n_fail = 0;
        comparisons = 0;
        cycleCount = 0;
        forever #5 core_clk = ~core_clk;
    end

    // Hang guard
    always @(posedge core_clk) begin
        cycleCount <= cycleCount + 1;
        if (cycleCount == 30000) begin
            n_fail = n_fail + 1;
            final_report();
        end
    end

    task automatic final_report();
        if (n_fail == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons = comparisons + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // Synchronous reset held two cycles
    task automatic rst();
        @(posedge core_clk);
        reset_n <= 1'b0;
        tick(2);
        reset_n <= 1'b1;
        tick(1);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        regReq.wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        regReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        regReq.rd <= 1'b0;
        #1 check(regRdData, exp);
    endtask

    // One conversion plus time for sync and flag update
    task automatic cv(input logic z, input logic [7:0] d, input logic f);
        conv.convert(z, d, f);
        tick(4);
    endtask

    task automatic oe(input logic alertExp, input logic otExp);
        check({7'h00, alertOe}, {7'h00, alertExp});
        check({7'h00, overtempOe}, {7'h00, otExp});
        check({6'h00, alertOut, overtempOut}, 8'h00);
    endtask

    initial begin
        rst();
        // Power-on values, unmapped place, read-only status bits
        rd(tal_pkg::OFS_LOCAL_LOW, tal_pkg::RST_LOCAL_LOW);
        rd(tal_pkg::OFS_REMOTE_HIGH, tal_pkg::RST_REMOTE_HIGH);
        rd(tal_pkg::OFS_OT_LIMIT, tal_pkg::RST_OT_LIMIT);
        rd(8'h05, tal_pkg::UNMAPPED_DATA);
        wr(tal_pkg::OFS_CONFIG, 8'hE0);
        rd(tal_pkg::OFS_CONFIG, 8'h00);
        // Every depth code, with a broken run restarting the count
        for (int d = 0; d < 4; d++) begin
            rst();
            cnt = depthCnt[d];
            wr(tal_pkg::OFS_CONFIG, {3'h0, d[1:0], 3'h0});
            repeat (cnt - 1) cv(1'b0, 8'h60, 1'b0);
            cv(1'b0, 8'h4E, 1'b0);
            repeat (cnt - 1) cv(1'b0, 8'h60, 1'b0);
            oe(1'b0, 1'b0);
            cv(1'b0, 8'h60, 1'b0);
            oe(1'b1, 1'b0);
            rd(tal_pkg::OFS_CONFIG, {3'h4, d[1:0], 3'h0});
            rd(tal_pkg::OFS_LOCAL_READING, 8'h60);
        end
        // Comparator operation and sleep
        rst();
        cv(1'b0, 8'h60, 1'b0);
        oe(1'b1, 1'b0);
        cv(1'b0, 8'h4E, 1'b0);
        oe(1'b1, 1'b0);
        cv(1'b0, 8'h4B, 1'b0);
        oe(1'b0, 1'b0);
        rd(tal_pkg::OFS_CONFIG, 8'h00);
        cv(1'b0, 8'h60, 1'b0);
        wr(tal_pkg::OFS_CONFIG, 8'h01);
        tick(2);
        check({7'h00, convEnable}, 8'h00);
        oe(1'b1, 1'b0);
        cv(1'b0, 8'h40, 1'b0);
        oe(1'b1, 1'b0);
        rd(tal_pkg::OFS_LOCAL_READING, 8'h60);
        wr(tal_pkg::OFS_LOCAL_HIGH, 8'h7D);
        rd(tal_pkg::OFS_LOCAL_HIGH, 8'h7D);
        wr(tal_pkg::OFS_CONFIG, 8'h00);
        tick(2);
        check({7'h00, convEnable}, 8'h01);
        cv(1'b0, 8'h4B, 1'b0);
        oe(1'b0, 1'b0);
        // Latched interrupt operation
        rst();
        wr(tal_pkg::OFS_CONFIG, 8'h02);
        cv(1'b1, 8'h70, 1'b0);
        cv(1'b1, 8'h70, 1'b0);
        oe(1'b1, 1'b1);
        rd(tal_pkg::OFS_LOCAL_READING, 8'h00);
        oe(1'b0, 1'b1);
        rd(tal_pkg::OFS_CONFIG, 8'h62);
        rd(tal_pkg::OFS_CONFIG, 8'h22);
        cv(1'b1, 8'h70, 1'b0);
        oe(1'b0, 1'b1);
        cv(1'b1, 8'h50, 1'b0);
        oe(1'b1, 1'b0);
        rd(tal_pkg::OFS_REMOTE_READING, 8'h50);
        cv(1'b1, 8'h70, 1'b0);
        wr(tal_pkg::OFS_CONFIG, 8'h03);
        tick(2);
        oe(1'b0, 1'b1);
        rd(tal_pkg::OFS_CONFIG, 8'h23);
        // Masked polling with a diode fault, then sleep
        rst();
        wr(tal_pkg::OFS_CONFIG, 8'h04);
        cv(1'b1, 8'h00, 1'b1);
        oe(1'b0, 1'b1);
        rd(tal_pkg::OFS_REMOTE_READING, tal_pkg::FULL_SCALE);
        rd(tal_pkg::OFS_CONFIG, 8'h64);
        wr(tal_pkg::OFS_CONFIG, 8'h05);
        cv(1'b1, 8'h00, 1'b0);
        oe(1'b0, 1'b1);
        rd(tal_pkg::OFS_CONFIG, 8'h25);
        final_report();
    end
endmodule

`default_nettype wire
